// ==== hw/flash_cmd_pkg.sv ====
// constants for the reset, unique-id and parameter-table command block
package flash_cmd_pkg;
  localparam logic [7:0] RESET_ARM_CMD = 8'h66;
  localparam logic [7:0] RESET_GO_CMD = 8'h99;
  localparam logic [7:0] UNIQUE_ID_READ_CMD = 8'h4B;
  localparam logic [7:0] PARAM_TABLE_READ_CMD = 8'h5A;
  localparam logic [7:0] NO_OPERATION_CMD = 8'h00;
  localparam int UID_DUMMY_BYTES = 4;
  localparam int PT_ADDR_BYTES = 3;
  localparam int PT_DUMMY_BYTES = 1;
  localparam int UID_BITS = 128;
  localparam int PT_AW = 8;
  localparam int PT_DEPTH = 256;
  localparam logic [PT_AW-1:0] PT_LAST_ADDR = 8'hFF;
  localparam logic [7:0] PT_SIG_B0 = 8'h53;
  localparam logic [7:0] PT_SIG_B1 = 8'h46;
  localparam logic [7:0] PT_SIG_B2 = 8'h44;
  localparam logic [7:0] PT_SIG_B3 = 8'h50;
  localparam logic [7:0] PT_MINOR_REV = 8'h00;
  localparam logic [7:0] PT_MAJOR_REV = 8'h01;
  localparam logic [7:0] PT_NUM_HDR = 8'h01;
  localparam logic [7:0] PT_UNUSED = 8'hFF;
  localparam logic [7:0] PT_HDR_ID = 8'h00;
  localparam logic [PT_AW-1:0] PT_A_SIG0 = 8'h00;
  localparam logic [PT_AW-1:0] PT_A_SIG1 = 8'h01;
  localparam logic [PT_AW-1:0] PT_A_SIG2 = 8'h02;
  localparam logic [PT_AW-1:0] PT_A_SIG3 = 8'h03;
  localparam logic [PT_AW-1:0] PT_A_MINOR = 8'h04;
  localparam logic [PT_AW-1:0] PT_A_MAJOR = 8'h05;
  localparam logic [PT_AW-1:0] PT_A_NHDR = 8'h06;
  localparam logic [PT_AW-1:0] PT_A_UNUSED = 8'h07;
  localparam logic [PT_AW-1:0] PT_A_HDR_ID = 8'h08;
  localparam logic [7:0] PT_FILL = 8'hFF;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 32;
endpackage

// ==== hw/byte_stream_if.sv ====
// valid/ready byte stream between the command block and its fifo
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== hw/stream_fifo.sv ====
// flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wr_ff;
  logic [AW-1:0] rd_ff;
  logic [AW:0] cnt_ff;
  logic push;
  logic pop;

  // handshake flags
  assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_ff != '0);
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;
  assign out_data_out = mem_ff[rd_ff];

  // storage write
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk_in) begin
    if (clr_in) begin
      wr_ff <= '0;
      rd_ff <= '0;
      cnt_ff <= '0;
    end else begin
      if (push) begin
        wr_ff <= wr_ff + 1'b1;
      end
      if (pop) begin
        rd_ff <= rd_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ==== hw/flash_cmd_core.sv ====
// serial command block: software reset, unique id read, parameter table read
// Operation
// RULE1 - reset needs arm opcode then reset opcode
// RULE2 - reset returns standby, volatile state defaults
// RULE3 - any other command cancels armed reset
// RULE4 - reset aborts running program or erase
// RULE5 - host sends id opcode plus four dummies
// RULE6 - shift out 128-bit id on falling edges
// RULE7 - host sends opcode, address, dummy byte
// RULE8 - table byte shifted on falling edges
// RULE9 - any start address accepted
// RULE10 - address advances after each byte
// RULE11 - address wraps to zero, output continues
// RULE12 - chip select high stops data drive
// RULE13 - table read ignored while array busy
// RULE14 - byte four reads minor revision zero
// RULE15 - byte five reads major revision one
// RULE16 - byte six reads header count one
// RULE17 - byte seven always reads all ones
// RULE18 - byte eight reads header id zero
// RULE19 - bytes zero to three hold signature
// RULE20 - no-op only cancels armed reset
// RULE21 - chip select high keeps device standby
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_core
  import flash_cmd_pkg::*;
#(
  parameter logic [UID_BITS-1:0] UNIQUE_ID = 128'h0123456789ABCDEF0F1E2D3C4B5A6978 // arbitrary value
) (
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic CS_N_IN,
  input wire logic SCLK_IN,
  input wire logic SI_IN,
  output logic SO_OUT,
  output logic SO_OE_N_OUT,
  input wire logic ARRAY_BUSY_IN,
  output logic ARRAY_ABORT_OUT,
  output logic SOFT_RESET_OUT,
  output logic RESET_ARMED_OUT
);
  typedef enum logic [2:0] {ST_IDLE, ST_OPC, ST_ADDR, ST_DUMMY, ST_UID, ST_TABLE, ST_SKIP} state_e;

  // table lookup for one byte address
  function automatic logic [7:0] table_byte(input logic [PT_AW-1:0] a);
    logic [7:0] v;
    v = PT_FILL;
    unique case (a)
      PT_A_SIG0: v = PT_SIG_B0; // [RULE19]
      PT_A_SIG1: v = PT_SIG_B1; // [RULE19]
      PT_A_SIG2: v = PT_SIG_B2; // [RULE19]
      PT_A_SIG3: v = PT_SIG_B3; // [RULE19]
      PT_A_MINOR: v = PT_MINOR_REV; // [RULE14]
      PT_A_MAJOR: v = PT_MAJOR_REV; // [RULE15]
      PT_A_NHDR: v = PT_NUM_HDR; // [RULE16]
      PT_A_UNUSED: v = PT_UNUSED; // [RULE17]
      PT_A_HDR_ID: v = PT_HDR_ID; // [RULE18]
      default: v = PT_FILL;
    endcase
    return v;
  endfunction

  logic [2:0] cs_sync_ff;
  logic [2:0] sclk_sync_ff;
  logic [1:0] si_sync_ff;
  logic sel;
  logic rise;
  logic fall;
  logic cs_fall;
  state_e state_ff;
  state_e nxt_state;
  logic [7:0] shift_ff;
  logic [2:0] bit_ff;
  logic [1:0] cnt_ff;
  logic [7:0] opc_ff;
  logic [PT_AW-1:0] addr_ff;
  logic armed_ff;
  logic soft_rst_ff;
  logic abort_ff;
  logic [6:0] uid_idx_ff;
  logic so_ff;
  logic drive_ff;
  logic [7:0] out_byte_ff;
  logic byte_done;
  logic [7:0] byte_in;
  byte_stream_if tx ();
  byte_stream_if rx ();

  // two-stage synchronisers, third stage for edge detection
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN) begin
      cs_sync_ff <= 3'h7;
      sclk_sync_ff <= 3'h0;
      si_sync_ff <= 2'h0;
    end else begin
      cs_sync_ff <= {cs_sync_ff[1:0], CS_N_IN};
      sclk_sync_ff <= {sclk_sync_ff[1:0], SCLK_IN};
      si_sync_ff <= {si_sync_ff[0], SI_IN};
    end
  end

  // select level, select fall and serial clock edges from the synchronised pins
  assign sel = ~cs_sync_ff[1];
  assign cs_fall = cs_sync_ff[2] & ~cs_sync_ff[1];
  assign rise = sel & sclk_sync_ff[1] & ~sclk_sync_ff[2];
  assign fall = sel & ~sclk_sync_ff[1] & sclk_sync_ff[2];
  assign byte_in = {shift_ff[6:0], si_sync_ff[1]};
  assign byte_done = rise & (bit_ff == 3'h7);

  // input shift register, bits latched on rising clock edges
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !sel) begin
      shift_ff <= 8'h00;
      bit_ff <= 3'h0;
    end else if (rise) begin
      shift_ff <= byte_in; // [RULE7]
      bit_ff <= bit_ff + 3'h1;
    end
  end

  // command phase sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cs_fall) begin
          nxt_state = ST_OPC;
        end
      end
      ST_OPC: begin
        if (byte_done) begin
          if (byte_in == UNIQUE_ID_READ_CMD) begin
            nxt_state = ST_DUMMY; // [RULE5]
          end else if (byte_in == PARAM_TABLE_READ_CMD && !ARRAY_BUSY_IN) begin
            nxt_state = ST_ADDR;
          end else begin
            nxt_state = ST_SKIP; // [RULE13]
          end
        end
      end
      ST_ADDR: begin
        if (byte_done && cnt_ff == 2'(PT_ADDR_BYTES - 1)) begin
          nxt_state = ST_DUMMY;
        end
      end
      ST_DUMMY: begin
        if (byte_done && opc_ff == UNIQUE_ID_READ_CMD && cnt_ff == 2'(UID_DUMMY_BYTES - 1)) begin
          nxt_state = ST_UID; // [RULE5]
        end else if (byte_done && opc_ff == PARAM_TABLE_READ_CMD && cnt_ff == 2'(PT_DUMMY_BYTES - 1)) begin
          nxt_state = ST_TABLE; // [RULE7]
        end
      end
      ST_UID, ST_TABLE, ST_SKIP: nxt_state = state_ff;
      default: nxt_state = ST_IDLE;
    endcase
    if (!sel) begin
      nxt_state = ST_IDLE; // [RULE21] [RULE12]
    end
  end

  // state register
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || soft_rst_ff) begin
      state_ff <= ST_IDLE; // [RULE2]
    end else begin
      state_ff <= nxt_state;
    end
  end

  // opcode capture and byte counter within a phase
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !sel) begin
      opc_ff <= 8'h00;
      cnt_ff <= 2'h0;
    end else if (byte_done) begin
      if (state_ff == ST_OPC) begin
        opc_ff <= byte_in;
        cnt_ff <= 2'h0;
      end else if (state_ff != nxt_state) begin
        cnt_ff <= 2'h0;
      end else begin
        cnt_ff <= cnt_ff + 2'h1;
      end
    end
  end

  // table address: any start, advance per byte, wrap past top
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || soft_rst_ff) begin
      addr_ff <= '0; // [RULE2]
    end else if (byte_done && state_ff == ST_ADDR) begin
      addr_ff <= byte_in[PT_AW-1:0]; // [RULE9] low bits of the final address byte
    end else if (fall && state_ff == ST_TABLE && bit_ff == 3'h7) begin
      addr_ff <= (addr_ff == PT_LAST_ADDR) ? '0 : addr_ff + 1'b1; // [RULE10] [RULE11]
    end
  end

  // reset arm latch and two-step software reset
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || soft_rst_ff) begin
      armed_ff <= 1'b0;
      soft_rst_ff <= 1'b0;
      abort_ff <= 1'b0;
    end else begin
      soft_rst_ff <= 1'b0;
      abort_ff <= 1'b0;
      if (byte_done && state_ff == ST_OPC) begin
        if (byte_in == RESET_ARM_CMD) begin
          armed_ff <= 1'b1;
        end else if (byte_in == RESET_GO_CMD && armed_ff) begin
          soft_rst_ff <= 1'b1; // [RULE1]
          abort_ff <= ARRAY_BUSY_IN; // [RULE4]
          armed_ff <= 1'b0;
        end else begin
          armed_ff <= 1'b0; // [RULE3] [RULE20]
        end
      end
    end
  end

  // status outputs; abort is registered with the reset pulse so both stand one cycle
  assign SOFT_RESET_OUT = soft_rst_ff;
  assign ARRAY_ABORT_OUT = abort_ff; // [RULE4]
  assign RESET_ARMED_OUT = armed_ff;

  // the fifo feeds outgoing bytes; producer fills it from the address counter
  // the id phase loads the fifo but never pops it: id bits come from the parameter
  logic [PT_AW-1:0] fill_addr_ff;
  logic [1:0] uid_fill_ff;
  logic [2:0] uid_word_ff;
  logic fill_on;
  assign fill_on = (state_ff == ST_TABLE) || (state_ff == ST_UID);
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !fill_on) begin
      fill_addr_ff <= addr_ff;
      uid_word_ff <= 3'h0;
      uid_fill_ff <= 2'h0;
    end else if (tx.valid && tx.ready) begin
      fill_addr_ff <= (fill_addr_ff == PT_LAST_ADDR) ? '0 : fill_addr_ff + 1'b1; // [RULE11]
      uid_fill_ff <= uid_fill_ff + 2'h1;
      if (uid_fill_ff == 2'h3) begin
        uid_word_ff <= uid_word_ff + 3'h1;
      end
    end
  end
  assign tx.valid = fill_on && !(state_ff == ST_UID && uid_word_ff == 3'h4);
  assign tx.data = (state_ff == ST_TABLE) ? table_byte(fill_addr_ff) : 8'h00;

  stream_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) stream_fifo_inst (
    .clk_in(CLK_SYS_IN),
    .clr_in(SRST_IN | ~fill_on),
    .in_valid_in(tx.valid),
    .in_ready_out(tx.ready),
    .in_data_in(tx.data),
    .out_valid_out(rx.valid),
    .out_ready_in(rx.ready),
    .out_data_out(rx.data)
  );

  // next byte taken from fifo at the start of each output byte
  assign rx.ready = fall && bit_ff == 3'h0 && state_ff == ST_TABLE;

  // output shift: table bytes msb first, id bits msb first, on falling edges
  always_ff @(posedge CLK_SYS_IN) begin
    if (SRST_IN || !sel) begin
      so_ff <= 1'b0;
      drive_ff <= 1'b0; // [RULE12]
      uid_idx_ff <= 7'h7F;
      out_byte_ff <= 8'h00;
    end else if (fall && state_ff == ST_TABLE) begin
      drive_ff <= 1'b1;
      if (bit_ff == 3'h0) begin
        so_ff <= rx.data[7]; // [RULE8]
        out_byte_ff <= {rx.data[6:0], 1'b0};
      end else begin
        so_ff <= out_byte_ff[7]; // [RULE8]
        out_byte_ff <= {out_byte_ff[6:0], 1'b0};
      end
    end else if (fall && state_ff == ST_UID) begin
      drive_ff <= 1'b1;
      so_ff <= UNIQUE_ID[uid_idx_ff]; // [RULE6]
      uid_idx_ff <= uid_idx_ff - 7'h1;
    end
  end

  // output pin and its active-low enable
  assign SO_OUT = so_ff;
  assign SO_OE_N_OUT = ~drive_ff;

  // armed state dropped by any non-reset opcode
  a_arm_cancel: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (byte_done && state_ff == ST_OPC && byte_in != RESET_ARM_CMD) |=> !armed_ff) // [RULE3]
    else $error("armed reset not cleared");
  // reset pulse only after armed reset opcode
  a_reset_pair: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    $rose(soft_rst_ff) |-> $past(armed_ff) && $past(byte_done) && $past(byte_in) == RESET_GO_CMD) // [RULE1]
    else $error("reset without arm");
  // reset returns to idle next cycle
  a_reset_idle: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    soft_rst_ff |=> state_ff == ST_IDLE && !armed_ff) // [RULE2]
    else $error("reset did not restore standby");
  // abort follows reset while busy
  a_reset_abort: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    soft_rst_ff |-> ARRAY_ABORT_OUT == $past(ARRAY_BUSY_IN)) // [RULE4]
    else $error("busy operation not aborted");
  // busy blocks table read
  a_busy_reject: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (byte_done && state_ff == ST_OPC && ARRAY_BUSY_IN) |=> state_ff != ST_ADDR) // [RULE13]
    else $error("table read accepted while busy");
  // deselect releases data line within sync delay
  a_cs_release: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    $rose(cs_sync_ff[1]) |=> SO_OE_N_OUT && state_ff == ST_IDLE) // [RULE12] [RULE21]
    else $error("output still driven after deselect");
  // address wraps to zero past top
  a_addr_wrap: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (fall && state_ff == ST_TABLE && bit_ff == 3'h7 && addr_ff == PT_LAST_ADDR) |=> addr_ff == '0) // [RULE11]
    else $error("address did not wrap");
  // address advances by one per byte
  a_addr_step: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    (fall && state_ff == ST_TABLE && bit_ff == 3'h7 && addr_ff != PT_LAST_ADDR) |=> addr_ff == $past(addr_ff) + 1'b1) // [RULE10]
    else $error("address did not advance");
  // header constants
  a_hdr_bytes: assert property (@(posedge CLK_SYS_IN)
    table_byte(PT_A_MINOR) == 8'h00 && table_byte(PT_A_MAJOR) == 8'h01 && table_byte(PT_A_NHDR) == 8'h01
    && table_byte(PT_A_UNUSED) == 8'hFF && table_byte(PT_A_HDR_ID) == 8'h00) // [RULE14] [RULE15] [RULE16] [RULE17] [RULE18]
    else $error("table header byte wrong");
  // fifo holds the next table byte whenever the output needs one
  a_fifo_ready: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    rx.ready |-> rx.valid) // [RULE10]
    else $error("table byte not ready in fifo");
  // abort only ever comes with the reset pulse
  a_abort_pulse: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    ARRAY_ABORT_OUT |-> SOFT_RESET_OUT) // [RULE4]
    else $error("abort without software reset");
  // data line driven only in the id and table output phases
  a_drive_phase: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    !SO_OE_N_OUT |-> (state_ff == ST_TABLE || state_ff == ST_UID)) // [RULE12]
    else $error("data driven outside output phase");
  // refused or unknown commands keep the data line released
  a_skip_quiet: assert property (@(posedge CLK_SYS_IN) disable iff (SRST_IN)
    state_ff == ST_SKIP |-> SO_OE_N_OUT) // [RULE13]
    else $error("refused command drives data");
endmodule
`default_nettype wire

// ==== verif/spi_host_model.sv ====
// spi host model driving select, serial clock and data toward the command block
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_in,
  output logic cs_n_out,
  output logic sclk_out,
  output logic si_out,
  input wire logic so_in
);
  // 125 ns serial clock built from the system clock: 13 cycles low, 12 high
  localparam int LOW_CYC = 13;
  localparam int HIGH_CYC = 12;
  localparam int GAP_CYC = 60;
  // serial clock rests low outside frames except while xfer is called with select high
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    si_out = 1'b0;
  end
  // one byte msb first: data set while clock low, reply sampled at the rising edge
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      si_out <= tx[i];
      repeat (LOW_CYC) @(posedge clk_in);
      sclk_out <= 1'b1;
      rx[i] = so_in;
      repeat (HIGH_CYC) @(posedge clk_in);
      sclk_out <= 1'b0;
    end
  endtask
  // select, opcode, then address and dummy bytes as the command needs
  task automatic open_cmd(input logic [7:0] op, input int n_extra, input logic [23:0] addr);
    logic [7:0] rx;
    @(posedge clk_in);
    cs_n_out <= 1'b0;
    repeat (LOW_CYC) @(posedge clk_in);
    xfer(op, rx);
    for (int k = 0; k < n_extra; k++) begin
      xfer((k < 3) ? addr[23-8*k -: 8] : 8'h00, rx);
    end
  endtask
  // frame ends by raising select half a clock after the last fall, then a quiet gap
  task automatic close_cmd();
    repeat (LOW_CYC) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (GAP_CYC) @(posedge clk_in);
  endtask
endmodule
`default_nettype wire

// ==== verif/flash_reset_uid_sfdp_cmds_bench.sv ====
// self-checking bench for the reset, unique id and parameter table commands
`timescale 1ns/1ps
`default_nettype none
module flash_reset_uid_sfdp_cmds_bench;
  import flash_cmd_pkg::*;
  localparam logic [127:0] ID = 128'hC3A51E2D9F8077660011223344556AB7; // arbitrary value
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic busy = 1'b0;
  logic cs_n, sclk, si, so, so_oe_n, abort, soft_rst, armed;
  logic so_line;
  int errors = 0;
  int n_checks = 0;
  int n_rst = 0;
  int n_abort = 0;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  flash_cmd_core #(.UNIQUE_ID(ID)) flash_cmd_core_inst (
    .CLK_SYS_IN(clk_sys), .SRST_IN(srst), .CS_N_IN(cs_n), .SCLK_IN(sclk), .SI_IN(si),
    .SO_OUT(so), .SO_OE_N_OUT(so_oe_n), .ARRAY_BUSY_IN(busy), .ARRAY_ABORT_OUT(abort),
    .SOFT_RESET_OUT(soft_rst), .RESET_ARMED_OUT(armed)
  );
  // a released data line shows the inverse of its last bit, no pull resistor assumed
  assign so_line = so_oe_n ? ~so : so;
  spi_host_model spi_host_model_inst (
    .clk_in(clk_sys), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si), .so_in(so_line)
  );

  // count reset and abort pulses
  always @(posedge clk_sys) begin
    if (soft_rst === 1'b1) n_rst++;
    if (abort === 1'b1) n_abort++;
  end

  task automatic check(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] op);
    spi_host_model_inst.open_cmd(op, 0, 24'h000000);
    spi_host_model_inst.close_cmd();
  endtask

  // table read of n bytes, expected bytes packed first-byte-highest
  task automatic pt_read(input logic [23:0] a, input int n, input logic [71:0] exp);
    logic [7:0] rx;
    spi_host_model_inst.open_cmd(PARAM_TABLE_READ_CMD, 4, a);
    for (int k = 0; k < n; k++) begin
      spi_host_model_inst.xfer(8'h00, rx);
      check(rx, exp[71-8*k -: 8], "table byte");
    end
    check(so_oe_n, 1'b0, "output driven");
    spi_host_model_inst.close_cmd();
    check(so_oe_n, 1'b1, "output released");
  endtask

  task automatic t_table();
    pt_read(24'h000000, 9, {PT_SIG_B0, PT_SIG_B1, PT_SIG_B2, PT_SIG_B3, 40'h000101FF00});
    $display("done table header");
  endtask

  task automatic t_wrap();
    pt_read(24'h7A01FE, 4, {16'hFFFF, PT_SIG_B0, PT_SIG_B1, 40'h0});
    $display("done unaligned wrap");
  endtask

  task automatic t_uid();
    logic [127:0] got;
    logic [7:0] rx;
    spi_host_model_inst.open_cmd(UNIQUE_ID_READ_CMD, 4, 24'h000000);
    for (int k = 0; k < 16; k++) begin
      spi_host_model_inst.xfer(8'h00, rx);
      got[127-8*k -: 8] = rx;
    end
    spi_host_model_inst.close_cmd();
    check(got, ID, "unique id");
    check(so_oe_n, 1'b1, "id output released");
    $display("done unique id");
  endtask

  task automatic t_reset();
    int r0;
    int a0;
    r0 = n_rst;
    a0 = n_abort;
    cmd(RESET_ARM_CMD);
    check(armed, 1'b1, "armed");
    check(n_rst - r0, 0, "no reset on arm alone");
    cmd(RESET_GO_CMD);
    check(n_rst - r0, 1, "reset pulse");
    check(armed, 1'b0, "armed cleared");
    check(n_abort - a0, 0, "no abort when idle");
    $display("done software reset");
  endtask

  task automatic t_cancel();
    logic [7:0] rx;
    int r0;
    r0 = n_rst;
    cmd(RESET_ARM_CMD);
    cmd(NO_OPERATION_CMD);
    check(armed, 1'b0, "no-op cancels");
    cmd(RESET_GO_CMD);
    check(n_rst - r0, 0, "late reset ignored");
    cmd(RESET_ARM_CMD);
    spi_host_model_inst.xfer(RESET_GO_CMD, rx);
    check(n_rst - r0, 0, "unselected clocks ignored");
    check(armed, 1'b1, "arm kept while unselected");
    pt_read(24'h000005, 1, {8'h01, 64'h0});
    check(armed, 1'b0, "other command cancels");
    cmd(RESET_GO_CMD);
    check(n_rst - r0, 0, "reset after read ignored");
    $display("done arm cancel");
  endtask

  task automatic t_busy();
    logic [7:0] rx;
    int r0;
    int a0;
    @(posedge clk_sys) busy <= 1'b1;
    a0 = n_abort;
    spi_host_model_inst.open_cmd(PARAM_TABLE_READ_CMD, 4, 24'h000000);
    spi_host_model_inst.xfer(8'h00, rx);
    check(so_oe_n, 1'b1, "table read refused when busy");
    spi_host_model_inst.close_cmd();
    check(n_abort - a0, 0, "busy cycle undisturbed");
    r0 = n_rst;
    cmd(RESET_ARM_CMD);
    cmd(RESET_GO_CMD);
    check(n_abort - a0, 1, "reset aborts array work");
    check(n_rst - r0, 1, "reset while busy");
    @(posedge clk_sys) busy <= 1'b0;
    $display("done busy array");
  endtask

  // run cut short if anything hangs
  initial begin
    repeat (90000) @(posedge clk_sys);
    errors++;
    $display("CHECK FAILED %0t run timed out", $time);
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_sys);
    srst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    t_table();
    t_wrap();
    t_uid();
    t_reset();
    t_cancel();
    t_busy();
    t_table();
    conclude();
  end
endmodule
`default_nettype wire
